// *** rtl/ppsc_top.sv ***
// design: power state control/status registers with wake event and soft reset
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: soft reset leaves control/status intact
// R2: D3hot to D0 resets standard registers
// R3: soft reset spares vendor and PM registers
// R4: wake event sets status regardless of enable
// R5: writing one clears status, releases wake
// R6: wake output only while enable bit set
// R7: data scale and select read zero
// R8: dynamic data wake enable reads zero
// R9: reserved control bits read zero
// R10: state field reads and writes power state
// R11: bridge enable bit reads one
// R12: disabled control leaves secondary bus alone
// R13: select bit picks clock stop or power
// R14: secondary action only when control enabled
// R15: reserved bridge bits read zero
// R16: one-shot soft reset on D3hot to D0
module ppsc_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        wake_event,
  output logic             wake_out,
  output logic             std_reg_reset,
  output logic             sec_clock_stop,
  output logic             sec_power_off,
  output logic      [1:0]  power_state,
  output logic             irq
);

  // ***************************************************************
  // register state
  // ***************************************************************
  logic [1:0]           state;
  logic                 wake_enable;
  logic                 wake_status;
  logic [ppsc_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [ppsc_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic                 wr_ctrl;
  logic                 wr_istat;
  logic                 wr_imask;
  logic                 leave_d3;
  logic [15:0]          next_rdata;
  logic [ppsc_pkg::IRQ_WIDTH-1:0] irq_events;

  // fixed bridge extension byte; both bits constant in this part
  localparam logic [7:0] BRIDGE_EXT = ppsc_pkg::BRIDGE_EXT_RST;
  localparam logic bridge_en  = BRIDGE_EXT[ppsc_pkg::BRIDGE_EN_BIT];  // [R11]
  localparam logic bridge_sel = BRIDGE_EXT[ppsc_pkg::BRIDGE_SEL_BIT];

  // address match, shared by every write decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // write decode
  assign wr_ctrl  = reg_wr && addr_hit(reg_addr, ppsc_pkg::OFS_CTRL_STATUS);
  assign wr_istat = reg_wr && addr_hit(reg_addr, ppsc_pkg::OFS_IRQ_STATUS);
  assign wr_imask = reg_wr && addr_hit(reg_addr, ppsc_pkg::OFS_IRQ_MASK);
  // leaving D3hot for D0 by a state field write
  assign leave_d3 = wr_ctrl && (state == ppsc_pkg::PPSC_D3HOT)
                 && (reg_wdata[1:0] == ppsc_pkg::PPSC_D0);  // [R16]

  // ***************************************************************
  // control/status register
  // ***************************************************************
  // state field: sys_rst or a control write of D0 clears it, the soft reset never does
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ppsc_pkg::CTRL_STATUS_RST[1:0];
    end else if (wr_ctrl) begin
      state <= reg_wdata[1:0];  // [R10] [R1]
    end
  end

  // enable bit, writable, untouched by the soft reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_enable <= ppsc_pkg::CTRL_STATUS_RST[ppsc_pkg::WAKE_ENABLE_BIT];
    end else if (wr_ctrl) begin
      wake_enable <= reg_wdata[ppsc_pkg::WAKE_ENABLE_BIT];  // [R1] [R3]
    end
  end

  // sticky status: set independent of enable, set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_status <= ppsc_pkg::CTRL_STATUS_RST[ppsc_pkg::WAKE_STATUS_BIT];
    end else if (wake_event) begin
      wake_status <= 1'b1;  // [R4]
    end else if (wr_ctrl && reg_wdata[ppsc_pkg::WAKE_STATUS_BIT]) begin
      wake_status <= 1'b0;  // [R5]
    end
  end

  // wake output follows status gated by enable; clearing status releases it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= wake_status && wake_enable;  // [R6] [R5]
    end
  end

  // ***************************************************************
  // soft reset and secondary bus control
  // ***************************************************************
  // one-cycle pulse to the standard register groups only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      std_reg_reset <= 1'b0;
    end else begin
      std_reg_reset <= leave_d3;  // [R16] [R2] [R3]
    end
  end

  // secondary action in D3hot; with control disabled nothing is touched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sec_clock_stop <= 1'b0;
      sec_power_off  <= 1'b0;
      power_state    <= 2'h0;
    end else begin
      sec_clock_stop <= bridge_en && bridge_sel
                     && (state == ppsc_pkg::PPSC_D3HOT);  // [R13] [R14] [R12]
      sec_power_off  <= bridge_en && !bridge_sel
                     && (state == ppsc_pkg::PPSC_D3HOT);  // [R13] [R14] [R12]
      power_state    <= state;
    end
  end

  // ***************************************************************
  // interrupt status and mask
  // ***************************************************************
  assign irq_events = {leave_d3, wake_event};

  // sticky bits, write one to clear, a new event beats the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status <= ppsc_pkg::IRQ_RST;
    end else begin
      irq_status <= irq_events
                  | (irq_status & ~(wr_istat ? reg_wdata[1:0] : 2'h0));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask <= ppsc_pkg::IRQ_RST;
    end else if (wr_imask) begin
      irq_mask <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  // constant control/status fields and reserved bits come back zero
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      ppsc_pkg::OFS_CTRL_STATUS: begin
        next_rdata[ppsc_pkg::WAKE_STATUS_BIT] = wake_status;  // [R7] [R8] [R9]
        next_rdata[ppsc_pkg::WAKE_ENABLE_BIT] = wake_enable;
        next_rdata[1:0] = state;  // [R10]
      end
      ppsc_pkg::OFS_BRIDGE_EXT: begin
        next_rdata[7:0] = BRIDGE_EXT;  // [R11] [R15]
      end
      ppsc_pkg::OFS_IRQ_STATUS: begin
        next_rdata[1:0] = irq_status;
      end
      ppsc_pkg::OFS_IRQ_MASK: begin
        next_rdata[1:0] = irq_mask;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ***************************************************************
  // control/status checks
  // ***************************************************************
  // enable clear keeps the wake output quiet
  a_wake_gated: assert property (@(posedge clk) disable iff (sys_rst)  // [R6]
    !wake_enable |=> !wake_out)
    else $error("wake output while enable clear");

  // pending status with enable drives the wake output
  a_wake_follow: assert property (@(posedge clk) disable iff (sys_rst)  // [R6]
    wake_status && wake_enable |=> wake_out)
    else $error("wake output missing");

  // no pending status, no wake output
  a_wake_release: assert property (@(posedge clk) disable iff (sys_rst)  // [R5]
    !wake_status |=> !wake_out)
    else $error("wake output without status");

  // an event always lands in status
  a_status_set: assert property (@(posedge clk) disable iff (sys_rst)  // [R4]
    wake_event |=> wake_status)
    else $error("wake status not set by event");

  // status never sets without an event
  a_status_only: assert property (@(posedge clk) disable iff (sys_rst)  // [R4]
    !wake_status && !wake_event |=> !wake_status)
    else $error("wake status set without event");

  // status is sticky until software writes
  a_status_hold: assert property (@(posedge clk) disable iff (sys_rst)  // [R5]
    wake_status && !wr_ctrl |=> wake_status)
    else $error("wake status lost");

  // write one clears status, output follows a cycle later
  a_status_clear: assert property (@(posedge clk) disable iff (sys_rst)  // [R5]
    wr_ctrl && reg_wdata[ppsc_pkg::WAKE_STATUS_BIT] && !wake_event
      |=> !wake_status ##1 !wake_out)
    else $error("wake status not cleared");

  // write zero leaves status alone
  a_zero_keep: assert property (@(posedge clk) disable iff (sys_rst)  // [R5]
    wr_ctrl && !reg_wdata[ppsc_pkg::WAKE_STATUS_BIT] && !wake_event
      |=> wake_status == $past(wake_status))
    else $error("writing zero changed status");

  // enable bit takes the written value
  a_enable_write: assert property (@(posedge clk) disable iff (sys_rst)  // [R6]
    wr_ctrl |=> wake_enable == $past(reg_wdata[ppsc_pkg::WAKE_ENABLE_BIT]))
    else $error("enable not written");

  // enable bit moves only on a control write
  a_enable_hold: assert property (@(posedge clk) disable iff (sys_rst)  // [R6]
    !wr_ctrl |=> $stable(wake_enable))
    else $error("enable changed without write");

  // state takes the written code, output copy a cycle later
  a_state_write: assert property (@(posedge clk) disable iff (sys_rst)  // [R10]
    wr_ctrl |=> state == $past(reg_wdata[1:0])
      ##1 power_state == $past(reg_wdata[1:0], 2))
    else $error("state not written");

  // state moves only on a control write
  a_state_hold: assert property (@(posedge clk) disable iff (sys_rst)  // [R10]
    !wr_ctrl |=> $stable(state))
    else $error("state changed without write");

  // state output mirrors the field one cycle late
  a_power_mirror: assert property (@(posedge clk) disable iff (sys_rst)  // [R10]
    power_state == $past(state))
    else $error("state output wrong");

  // ***************************************************************
  // soft reset and secondary bus checks
  // ***************************************************************
  // leaving D3hot gives exactly one pulse
  a_reset_pulse: assert property (@(posedge clk) disable iff (sys_rst)  // [R16]
    wr_ctrl && state == ppsc_pkg::PPSC_D3HOT && reg_wdata[1:0] == ppsc_pkg::PPSC_D0
      |=> std_reg_reset ##1 !std_reg_reset)
    else $error("soft reset pulse wrong");

  // no pulse without the D3hot to D0 write
  a_pulse_cause: assert property (@(posedge clk) disable iff (sys_rst)  // [R16]
    !leave_d3 |=> !std_reg_reset)
    else $error("soft reset without cause");

  // control fields hold what the leaving write put there
  a_reset_keep: assert property (@(posedge clk) disable iff (sys_rst)  // [R1]
    std_reg_reset |-> state == ppsc_pkg::PPSC_D0
      && wake_enable == $past(reg_wdata[ppsc_pkg::WAKE_ENABLE_BIT]))
    else $error("soft reset disturbed control");

  // pending wake status survives the soft reset
  a_wake_survive: assert property (@(posedge clk) disable iff (sys_rst)  // [R1] [R3]
    leave_d3 && !reg_wdata[ppsc_pkg::WAKE_STATUS_BIT] && wake_status |=> wake_status)
    else $error("soft reset cleared wake status");

  // leaving write lands in D0
  a_leave_state: assert property (@(posedge clk) disable iff (sys_rst)  // [R16]
    leave_d3 |=> state == ppsc_pkg::PPSC_D0)
    else $error("not in D0 after leaving D3hot");

  // D3hot stops the secondary clock
  a_clock_stop: assert property (@(posedge clk) disable iff (sys_rst)  // [R13]
    state == ppsc_pkg::PPSC_D3HOT |=> sec_clock_stop && !sec_power_off)
    else $error("D3hot action wrong");

  // outside D3hot the secondary clock runs
  a_clock_run: assert property (@(posedge clk) disable iff (sys_rst)  // [R14]
    state != ppsc_pkg::PPSC_D3HOT |=> !sec_clock_stop)
    else $error("secondary clock stopped outside D3hot");

  // select bit set, so power is never removed
  a_power_kept: assert property (@(posedge clk) disable iff (sys_rst)  // [R13]
    !sec_power_off)
    else $error("secondary power removed");

  // ***************************************************************
  // read path and interrupt checks
  // ***************************************************************
  // data scale and select read zero
  a_ctrl_zeros: assert property (@(posedge clk) disable iff (sys_rst)  // [R7]
    $past(reg_rd) && $past(reg_addr) == ppsc_pkg::OFS_CTRL_STATUS
      |-> reg_rdata[14:9] == 6'h00 && reg_rdata[7:2] == 6'h00)
    else $error("constant control bits not zero");

  // dynamic data wake enable reads zero
  a_dyn_zero: assert property (@(posedge clk) disable iff (sys_rst)  // [R8]
    $past(reg_rd) && $past(reg_addr) == ppsc_pkg::OFS_CTRL_STATUS |-> !reg_rdata[4])
    else $error("dynamic data enable not zero");

  // reserved control bits read zero
  a_resv_zero: assert property (@(posedge clk) disable iff (sys_rst)  // [R9]
    $past(reg_rd) && $past(reg_addr) == ppsc_pkg::OFS_CTRL_STATUS
      |-> reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0)
    else $error("reserved control bits not zero");

  // state field reads back the current state
  a_ctrl_read: assert property (@(posedge clk) disable iff (sys_rst)  // [R10]
    reg_rd && reg_addr == ppsc_pkg::OFS_CTRL_STATUS |=> reg_rdata[1:0] == $past(state))
    else $error("state read wrong");

  // status bit reads back pending wake
  a_status_read: assert property (@(posedge clk) disable iff (sys_rst)  // [R4]
    reg_rd && reg_addr == ppsc_pkg::OFS_CTRL_STATUS
      |=> reg_rdata[ppsc_pkg::WAKE_STATUS_BIT] == $past(wake_status))
    else $error("wake status read wrong");

  // bridge byte reads its fixed value
  a_bridge_read: assert property (@(posedge clk) disable iff (sys_rst)  // [R11]
    reg_rd && reg_addr == ppsc_pkg::OFS_BRIDGE_EXT |=> reg_rdata == 16'h00C0)
    else $error("bridge byte wrong");

  // select bit reads one: clock stop in D3hot
  a_select_read: assert property (@(posedge clk) disable iff (sys_rst)  // [R13]
    reg_rd && reg_addr == ppsc_pkg::OFS_BRIDGE_EXT |=> reg_rdata[6])
    else $error("select bit not one");

  // reserved bridge bits read zero
  a_bridge_resv: assert property (@(posedge clk) disable iff (sys_rst)  // [R15]
    reg_rd && reg_addr == ppsc_pkg::OFS_BRIDGE_EXT
      |=> reg_rdata[5:0] == 6'h00 && reg_rdata[15:8] == 8'h00)
    else $error("reserved bridge bits not zero");

  // wake event also lands in the interrupt status
  a_irq_wake: assert property (@(posedge clk) disable iff (sys_rst)  // [R4]
    wake_event |=> irq_status[ppsc_pkg::IRQ_WAKE_BIT])
    else $error("wake interrupt status not set");

  // soft reset lands in the interrupt status
  a_irq_soft: assert property (@(posedge clk) disable iff (sys_rst)  // [R16]
    leave_d3 |=> irq_status[ppsc_pkg::IRQ_RESET_BIT])
    else $error("soft reset interrupt status not set");

  // interrupt level follows masked status
  a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    irq == $past(|(irq_status & irq_mask)))
    else $error("interrupt level wrong");

endmodule
`default_nettype wire

// *** pkg/ppsc_pkg.sv ***
// package: register map, field layout and constants of the power state control block
package ppsc_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL_STATUS = 8'hA4;
  localparam logic [7:0]  OFS_BRIDGE_EXT  = 8'hA6;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'hB0;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'hB4;
  // control/status field positions
  localparam int          WAKE_STATUS_BIT = 15;
  localparam int          WAKE_ENABLE_BIT = 8;
  localparam int          STATE_LSB       = 0;
  // reset values and bridge extension bit positions
  localparam logic [15:0] CTRL_STATUS_RST = 16'h0000;
  localparam logic [7:0]  BRIDGE_EXT_RST  = 8'hC0;
  localparam int          BRIDGE_EN_BIT   = 7;
  localparam int          BRIDGE_SEL_BIT  = 6;
  // interrupt status bits
  localparam int          IRQ_WAKE_BIT    = 0;
  localparam int          IRQ_RESET_BIT   = 1;
  localparam int          IRQ_WIDTH       = 2;
  localparam logic [1:0]  IRQ_RST         = 2'h0;
  // power states
  typedef enum logic [1:0] {
    PPSC_D0 = 2'h0,
    PPSC_D1 = 2'h1,
    PPSC_D2 = 2'h2,
    PPSC_D3HOT = 2'h3
  } ppsc_state_t;
endpackage

// *** verif/ppsc_host.sv ***
// host model: register port master for the power state block
`timescale 1ns/1ps
`default_nettype none
module ppsc_host (
  input  wire logic        clk,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // ****************
  // bus access tasks
  // ****************
  // idle bus from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // leading edge wait keeps strobes apart, so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** verif/ppsc_tb_top.sv ***
// testbench: registers, wake event, interrupts and soft reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module ppsc_tb_top;
  // ***********
  // environment
  // ***********
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wake_event = 1'b0;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        wake_out;
  logic        std_reg_reset;
  logic        sec_clock_stop;
  logic        sec_power_off;
  logic [1:0]  power_state;
  logic        irq;
  logic [1:0]  seq [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  int          n_fail = 0;
  int          compares = 0;
  int          n_rst = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  // soft reset pulse counter, catches a pulse longer than one cycle too
  always @(posedge clk) if (std_reg_reset === 1'b1) n_rst++;
  ppsc_top ppsc_top_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .wake_event(wake_event),
    .wake_out(wake_out),
    .std_reg_reset(std_reg_reset),
    .sec_clock_stop(sec_clock_stop),
    .sec_power_off(sec_power_off),
    .power_state(power_state),
    .irq(irq)
  );
  ppsc_host ppsc_host_i (
    .clk(clk),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );
  // read and compare
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string n);
    logic [15:0] d;
    ppsc_host_i.rd(a, d);
    `CHK(n, e, d)
  endtask
  // registered outputs settle one cycle after the register
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK("outs", 7'h00, {wake_out, std_reg_reset, sec_clock_stop, sec_power_off, power_state, irq})
    rchk(8'hA4, 16'h0000, "ctrl");
    rchk(8'hA6, 16'h00C0, "bridge");
    rchk(8'h50, 16'h0000, "unmapped");
    ppsc_host_i.wr(8'hA6, 16'h003F);
    rchk(8'hA6, 16'h00C0, "bridge_ro");
    ppsc_host_i.wr(8'hA4, 16'h7FFF);
    settle();
    `CHK("clk_stop", 2'h2, {sec_clock_stop, sec_power_off})
    rchk(8'hA4, 16'h0103, "ctrl_ro");
    ppsc_host_i.wr(8'hA4, 16'h0100);
    settle();
    `CHK("soft_rst", 1, n_rst)
    `CHK("clk_run", 1'b0, sec_clock_stop)
    rchk(8'hA4, 16'h0100, "ctrl_kept");
    rchk(8'hB0, 16'h0002, "irq_rst");
    foreach (seq[i]) begin
      ppsc_host_i.wr(8'hA4, {14'h0000, seq[i]});
      rchk(8'hA4, {14'h0000, seq[i]}, "state");
      `CHK("pout", seq[i], power_state)
    end
    `CHK("no_rst", 1, n_rst)
    ppsc_host_i.wr(8'hA4, 16'h0000);
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    settle();
    `CHK("wake_off", 1'b0, wake_out)
    rchk(8'hA4, 16'h8000, "wake_sts");
    ppsc_host_i.wr(8'hA4, 16'h0000);
    rchk(8'hA4, 16'h8000, "w0_keep");
    ppsc_host_i.wr(8'hA4, 16'h0100);
    settle();
    `CHK("wake_on", 1'b1, wake_out)
    ppsc_host_i.wr(8'hA4, 16'h8100);
    settle();
    `CHK("wake_clr", 1'b0, wake_out)
    rchk(8'hA4, 16'h0100, "sts_clr");
    `CHK("irq_mask", 1'b0, irq)
    ppsc_host_i.wr(8'hB4, 16'h0001);
    settle();
    `CHK("irq_wake", 1'b1, irq)
    ppsc_host_i.wr(8'hB0, 16'h0001);
    settle();
    `CHK("irq_clr", 1'b0, irq)
    ppsc_host_i.wr(8'hB4, 16'h0003);
    settle();
    `CHK("irq_soft", 1'b1, irq)
    ppsc_host_i.wr(8'hB0, 16'h0003);
    rchk(8'hB0, 16'h0000, "irq_sts");
    rchk(8'hB4, 16'h0003, "irq_msk");
    results();
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
